// ### adc_calibration_control.v
// calibration control register and calibration sequencer for the 12-bit converter
// Summary of operation
// - busy bit 7 stays high for every running conversion or calibration
// - busy bit is read-only; writes do not change it
// - busy bit clears itself when the cycle finishes
// - bit 6 low applies gain coefficient; high leaves results without it
// - bits 5:4 choose readings averaged per bit: 00 gives 15, 11 gives 63
// - bit 3 low applies offset coefficient; high excludes it
// - bit 1 low selects offset calibration, high selects gain calibration
// - writing 1 to bit 0 launches calibration of the selected type
// - start bit clears itself when calibration completes
// - register reads zero after reset, nothing running
// - invalid channel code 0111 connects no input
// - codes 0000-0101 pick external inputs 0-5; 0110 picks nothing
`include "adc_calibration_control_regs.vh"
module adc_calibration_control #(
	parameter DATA_W = 12
) (
	// clock and reset
	input wire clock,
	input wire sys_rst,
	// special function register port of the core
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire [7:0] sfr_wdata,
	output reg [7:0] sfr_rdata,
	// channel select field from the channel register
	input wire [3:0] chan_sel,
	// converter conversion status
	input wire conv_start,
	input wire conv_done,
	// converter sample path
	input wire sample_valid,
	input wire [DATA_W-1:0] sample,
	// converter steering
	output reg [5:0] ext_chan_enable,
	output reg temp_sensor_sel,
	output reg first_dac_output_sel,
	output reg second_dac_output_sel,
	output reg agnd_sel,
	output reg vref_sel,
	output reg cal_active,
	output reg cal_zero_scale,
	output reg sar_bit_strobe,
	output reg [DATA_W-1:0] sar_trial,
	output reg gain_coef_enable,
	output reg offset_coef_enable,
	output reg [DATA_W-1:0] offset_coef,
	output reg [DATA_W-1:0] gain_coef
);
	// ****************************************
	// state
	// ****************************************
	localparam ST_IDLE = 2'b00;
	localparam ST_AVG = 2'b01;
	localparam ST_DECIDE = 2'b10;
	localparam ST_STORE = 2'b11;
	localparam [31:0] TOP_BIT = `SAR_BITS - 1;

	reg [1:0] state_reg;
	reg gain_coef_disable;
	reg avg_count_sel_hi;
	reg avg_count_sel_lo;
	reg offset_coef_disable;
	reg cal_mode_select;
	reg cal_type_select;
	reg cal_start;
	reg conv_busy_reg;
	reg avg_clear_reg;
	reg [3:0] bit_idx_reg;
	reg [DATA_W-1:0] trial_reg;
	wire avg_done;
	wire [DATA_W-1:0] avg_value;
	wire busy;
	wire reg_write;
	wire [7:0] reg_value;

	// ****************************************
	// decoding functions
	// ****************************************
	function [7:0] avg_target;
		input [1:0] code;
		begin
			case (code)
				2'b00: avg_target = `AVG_COUNT_00;
				2'b01: avg_target = `AVG_COUNT_01;
				2'b10: avg_target = `AVG_COUNT_10;
				default: avg_target = `AVG_COUNT_11;
			endcase
		end
	endfunction

	function [10:0] chan_decode;
		input [3:0] code;
		begin
			chan_decode = 11'h000;
			if (code <= `CHAN_LAST_EXTERNAL)
				chan_decode[code[2:0]] = 1'b1;
			else if (code == `CHAN_TEMP_SENSOR)
				chan_decode[6] = 1'b1;
			else if (code == `CHAN_FIRST_DAC)
				chan_decode[7] = 1'b1;
			else if (code == `CHAN_SECOND_DAC)
				chan_decode[8] = 1'b1;
			else if (code == `CHAN_AGND)
				chan_decode[9] = 1'b1;
			else if (code == `CHAN_VREF)
				chan_decode[10] = 1'b1;
		end
	endfunction

	assign busy = conv_busy_reg || (state_reg != ST_IDLE);
	assign reg_write = sfr_wr && (sfr_addr == `CAL_CTRL_ADDR);
	assign reg_value = {busy, gain_coef_disable, avg_count_sel_hi, avg_count_sel_lo,
		offset_coef_disable, cal_mode_select, cal_type_select, cal_start};

	// ****************************************
	// control register
	// ****************************************
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			gain_coef_disable <= 1'b0;
			avg_count_sel_hi <= 1'b0;
			avg_count_sel_lo <= 1'b0;
			offset_coef_disable <= 1'b0;
			cal_mode_select <= 1'b0;
			cal_type_select <= 1'b0;
			cal_start <= 1'b0;
		end else begin
			if (reg_write) begin
				// busy bit 7 has no storage here, writes to it vanish
				gain_coef_disable <= sfr_wdata[`GAIN_COEF_DISABLE_BIT];
				avg_count_sel_hi <= sfr_wdata[`AVG_SEL_HI_BIT];
				avg_count_sel_lo <= sfr_wdata[`AVG_SEL_LO_BIT];
				offset_coef_disable <= sfr_wdata[`OFFSET_COEF_DISABLE_BIT];
				cal_mode_select <= sfr_wdata[`CAL_MODE_BIT];
				// type is frozen while a cycle runs so the store target cannot move
				if (state_reg == ST_IDLE)
					cal_type_select <= sfr_wdata[`CAL_TYPE_BIT];
				// writing 0 never aborts a cycle; only completion clears it
				if (sfr_wdata[`CAL_START_BIT])
					cal_start <= 1'b1;
			end
			if (state_reg == ST_STORE && !(reg_write && sfr_wdata[`CAL_START_BIT]))
				cal_start <= 1'b0;
		end
	end

	// ****************************************
	// conversion busy tracking
	// ****************************************
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			conv_busy_reg <= 1'b0;
		else if (conv_start)
			conv_busy_reg <= 1'b1;
		else if (conv_done)
			conv_busy_reg <= 1'b0;
	end

	// ****************************************
	// calibration sequencer: binary search of the coefficient
	// ****************************************
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			avg_clear_reg <= 1'b1;
			bit_idx_reg <= 4'h0;
			trial_reg <= {DATA_W{1'b0}};
			offset_coef <= {DATA_W{1'b0}};
			gain_coef <= {DATA_W{1'b0}};
			sar_bit_strobe <= 1'b0;
		end else begin
			avg_clear_reg <= 1'b0;
			sar_bit_strobe <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					avg_clear_reg <= 1'b1;
					// a conversion in flight holds off the calibration launch
					if (cal_start && !conv_busy_reg) begin
						state_reg <= ST_AVG;
						bit_idx_reg <= TOP_BIT[3:0];
						trial_reg <= {1'b1, {(DATA_W-1){1'b0}}};
					end
				end
				ST_AVG: begin
					// done still shows the previous bit during the clear cycle
					if (avg_done && !avg_clear_reg)
						state_reg <= ST_DECIDE;
				end
				ST_DECIDE: begin
					avg_clear_reg <= 1'b1;
					sar_bit_strobe <= 1'b1;
					// keep the trial bit while the averaged residue is still positive
					if (avg_value[DATA_W-1])
						trial_reg[bit_idx_reg] <= 1'b0;
					if (bit_idx_reg == 4'h0) begin
						state_reg <= ST_STORE;
					end else begin
						trial_reg[bit_idx_reg - 4'h1] <= 1'b1;
						bit_idx_reg <= bit_idx_reg - 4'h1;
						state_reg <= ST_AVG;
					end
				end
				default: begin
					if (cal_type_select)
						gain_coef <= trial_reg;
					else
						offset_coef <= trial_reg;
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	cal_averager #(
		.DATA_W(DATA_W)
	) u_averager (
		.clock(clock),
		.sys_rst(sys_rst),
		.clear(avg_clear_reg),
		.sample_valid(sample_valid && state_reg == ST_AVG),
		.sample(sample),
		.target_count(avg_target({avg_count_sel_hi, avg_count_sel_lo})),
		.done(avg_done),
		.average(avg_value)
	);

	// ****************************************
	// registered outputs
	// ****************************************
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sfr_rdata <= `CAL_CTRL_RESET;
			ext_chan_enable <= 6'h00;
			temp_sensor_sel <= 1'b0;
			first_dac_output_sel <= 1'b0;
			second_dac_output_sel <= 1'b0;
			agnd_sel <= 1'b0;
			vref_sel <= 1'b0;
			cal_active <= 1'b0;
			cal_zero_scale <= 1'b0;
			sar_trial <= {DATA_W{1'b0}};
			gain_coef_enable <= 1'b1;
			offset_coef_enable <= 1'b1;
		end else begin
			// unmapped addresses read back zero
			if (sfr_addr == `CAL_CTRL_ADDR)
				sfr_rdata <= reg_value;
			else
				sfr_rdata <= 8'h00;
			// codes 0110 and 0111 leave every input open
			{vref_sel, agnd_sel, second_dac_output_sel, first_dac_output_sel,
				temp_sensor_sel, ext_chan_enable} <= chan_decode(chan_sel);
			cal_active <= (state_reg != ST_IDLE);
			cal_zero_scale <= !cal_type_select;
			sar_trial <= trial_reg;
			gain_coef_enable <= !gain_coef_disable;
			offset_coef_enable <= !offset_coef_disable;
		end
	end
endmodule

// ### adc_calibration_control_regs.vh
// register offsets, field positions, reset values and counts for the calibration control block
`ifndef ADC_CALIBRATION_CONTROL_REGS_VH
`define ADC_CALIBRATION_CONTROL_REGS_VH
// ****************************************
// register map
// ****************************************
`define CAL_CTRL_ADDR 8'hf5
`define CAL_CTRL_RESET 8'h00
// ****************************************
// field positions
// ****************************************
`define BUSY_BIT 7
`define GAIN_COEF_DISABLE_BIT 6
`define AVG_SEL_HI_BIT 5
`define AVG_SEL_LO_BIT 4
`define OFFSET_COEF_DISABLE_BIT 3
`define CAL_MODE_BIT 2
`define CAL_TYPE_BIT 1
`define CAL_START_BIT 0
// ****************************************
// averaging counts per averaging code
// ****************************************
`define AVG_COUNT_00 8'h0f
`define AVG_COUNT_01 8'h1f
`define AVG_COUNT_10 8'h2f
`define AVG_COUNT_11 8'h3f
// ****************************************
// channel codes
// ****************************************
`define CHAN_LAST_EXTERNAL 4'h5
`define CHAN_INVALID_A 4'h6
`define CHAN_INVALID_B 4'h7
`define CHAN_TEMP_SENSOR 4'h8
`define CHAN_FIRST_DAC 4'h9
`define CHAN_SECOND_DAC 4'ha
`define CHAN_AGND 4'hb
`define CHAN_VREF 4'hc
`define SAR_BITS 12
`endif

// ### cal_averager.v
// averaging accumulator for one calibration bit decision
module cal_averager #(
	parameter DATA_W = 12
) (
	// clock and reset
	input wire clock,
	input wire sys_rst,
	// control
	input wire clear,
	input wire sample_valid,
	input wire [DATA_W-1:0] sample,
	input wire [7:0] target_count,
	// result
	output reg done,
	output reg [DATA_W-1:0] average
);
	reg [DATA_W+7:0] sum_reg;
	reg [7:0] count_reg;
	wire [DATA_W+7:0] sum_next;
	wire [7:0] count_next;

	assign sum_next = sum_reg + {8'h00, sample};
	assign count_next = count_reg + 8'h01;

	// divide by shifting: a true divide by 15 or 63 costs too much area
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sum_reg <= {(DATA_W+8){1'b0}};
			count_reg <= 8'h00;
			done <= 1'b0;
			average <= {DATA_W{1'b0}};
		end else if (clear) begin
			sum_reg <= {(DATA_W+8){1'b0}};
			count_reg <= 8'h00;
			done <= 1'b0;
		end else if (sample_valid && !done) begin
			sum_reg <= sum_next;
			count_reg <= count_next;
			if (count_next == target_count) begin
				done <= 1'b1;
				if (target_count > 8'h1f)
					average <= sum_next[DATA_W+5:6];
				else
					average <= sum_next[DATA_W+3:4];
			end
		end
	end
endmodule

// ### adc_calibration_control_assertions.sv
// port checks for the calibration control block
module adc_calibration_control_assertions #(
	parameter DATA_W = 12
) (
	// clock and reset
	input wire clock,
	input wire sys_rst,
	// register port
	input wire [7:0] sfr_addr,
	input wire sfr_wr,
	input wire [7:0] sfr_rdata,
	// steering
	input wire [3:0] chan_sel,
	input wire [5:0] ext_chan_enable,
	input wire temp_sensor_sel,
	input wire first_dac_output_sel,
	input wire second_dac_output_sel,
	input wire agnd_sel,
	input wire vref_sel,
	input wire cal_active,
	input wire cal_zero_scale,
	input wire sar_bit_strobe,
	input wire gain_coef_enable,
	input wire offset_coef_enable,
	input wire [DATA_W-1:0] offset_coef,
	input wire [DATA_W-1:0] gain_coef
);
	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	busy_in_cal_a: assert property (sar_bit_strobe && sfr_addr == 8'hf5 |=> sfr_rdata[7])
		else $error("busy low mid calibration");
	gain_enable_a: assert property ((sfr_addr == 8'hf5 && !sfr_wr) [*3] |-> gain_coef_enable == !sfr_rdata[6])
		else $error("gain enable wrong");
	offset_enable_a: assert property ((sfr_addr == 8'hf5 && !sfr_wr) [*3] |-> offset_coef_enable == !sfr_rdata[3])
		else $error("offset enable wrong");
	cal_type_a: assert property ((sfr_addr == 8'hf5 && !sfr_wr) [*3] |-> cal_zero_scale == !sfr_rdata[1])
		else $error("cal type wrong");
	type_hold_a: assert property (cal_active && $past(cal_active) |-> $stable(cal_zero_scale))
		else $error("cal type moved");
	strobe_in_cal_a: assert property (sar_bit_strobe |-> cal_active)
		else $error("strobe while idle");
	coef_hold_a: assert property (!cal_active && !$past(cal_active) |-> $stable(offset_coef) && $stable(gain_coef))
		else $error("coef moved while idle");
	gain_kept_a: assert property (cal_active && cal_zero_scale |-> $stable(gain_coef))
		else $error("gain coef moved");
	chan_none_a: assert property (!$past(sys_rst) && $stable(chan_sel) && chan_sel == 4'h7 |->
		{ext_chan_enable, temp_sensor_sel, first_dac_output_sel, second_dac_output_sel, agnd_sel, vref_sel} == 11'h000)
		else $error("invalid code selects");
	chan_ext_a: assert property (!$past(sys_rst) && $stable(chan_sel) && chan_sel < 4'h6 |->
		ext_chan_enable == 6'h01 << chan_sel)
		else $error("external select wrong");
endmodule
bind adc_calibration_control adc_calibration_control_assertions #(.DATA_W(DATA_W)) i_chk (.clock(clock),
	.sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .chan_sel(chan_sel),
	.ext_chan_enable(ext_chan_enable), .temp_sensor_sel(temp_sensor_sel), .first_dac_output_sel(first_dac_output_sel),
	.second_dac_output_sel(second_dac_output_sel), .agnd_sel(agnd_sel), .vref_sel(vref_sel), .cal_active(cal_active),
	.cal_zero_scale(cal_zero_scale), .sar_bit_strobe(sar_bit_strobe), .gain_coef_enable(gain_coef_enable),
	.offset_coef_enable(offset_coef_enable), .offset_coef(offset_coef), .gain_coef(gain_coef));

// ### adc_converter_model.sv
// converter model handing residue readings to the sequencer
module adc_converter_model (
	// clock and reset
	input wire clock,
	input wire sys_rst,
	// sequencer side
	input wire cal_active,
	input wire slow,
	output reg sample_valid,
	output reg [11:0] sample
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [1:0] gap_reg;
	// ****************************************
	// readings
	// ****************************************
	// data toggles outside valid cycles so a stale value never looks clean
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			gap_reg <= 2'h0;
			sample_valid <= 1'b0;
			sample <= 12'h000;
		end else begin
			gap_reg <= gap_reg + 2'h1;
			sample_valid <= cal_active && (!slow || gap_reg == 2'h0);
			sample <= (cal_active && (!slow || gap_reg == 2'h0)) ? 12'h020 : ~sample;
		end
	end
endmodule

// ### adc_calibration_control_tb.sv
// register level tests of the calibration control block
module adc_calibration_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, sys_rst, sfr_wr, conv_start, conv_done, slow, sample_valid, sar_bit_strobe, cal_active;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
	logic [3:0] chan_sel;
	logic [5:0] ext_chan_enable;
	logic temp_sensor_sel, first_dac_output_sel, second_dac_output_sel, agnd_sel, vref_sel, cal_zero_scale;
	logic gain_coef_enable, offset_coef_enable;
	logic [11:0] sample, sar_trial, offset_coef, gain_coef;
	int bad_count, checks_done, strobes, cyc, len0, len1;
	adc_calibration_control i_dut (.clock(clock), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .chan_sel(chan_sel), .conv_start(conv_start),
		.conv_done(conv_done), .sample_valid(sample_valid), .sample(sample), .ext_chan_enable(ext_chan_enable),
		.temp_sensor_sel(temp_sensor_sel), .first_dac_output_sel(first_dac_output_sel),
		.second_dac_output_sel(second_dac_output_sel), .agnd_sel(agnd_sel), .vref_sel(vref_sel),
		.cal_active(cal_active), .cal_zero_scale(cal_zero_scale), .sar_bit_strobe(sar_bit_strobe),
		.sar_trial(sar_trial), .gain_coef_enable(gain_coef_enable), .offset_coef_enable(offset_coef_enable),
		.offset_coef(offset_coef), .gain_coef(gain_coef));
	adc_converter_model i_conv (.clock(clock), .sys_rst(sys_rst), .cal_active(cal_active), .slow(slow),
		.sample_valid(sample_valid), .sample(sample));
	// ****************************************
	// tasks
	// ****************************************
	task automatic test_done;
		if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] v);
		@(negedge clock);
		sfr_wdata = v;
		sfr_wr = 1'b1;
		@(negedge clock);
		sfr_wr = 1'b0;
	endtask
	// address rests at the register so polling needs no extra cycle
	task automatic rd(input logic [7:0] a);
		@(negedge clock);
		sfr_addr = a;
		@(negedge clock);
		d = sfr_rdata;
		sfr_addr = 8'hf5;
	endtask
	task automatic wait_done(output int t);
		t = 0;
		do begin
			rd(8'hf5);
			t++;
		end while (d[0] && t < 5000);
		chk(d & 8'h81, 8'h00, "cycle end");
	endtask
	task automatic cal(input logic [1:0] avg, input logic typ, input logic sl, output int t);
		logic [11:0] keep;
		int n;
		slow = sl;
		keep = typ ? offset_coef : gain_coef;
		n = strobes;
		wr({2'b00, avg, 2'b01, typ, 1'b1});
		rd(8'hf5);
		chk(d & 8'h81, 8'h81, "busy at start");
		chk(cal_zero_scale, !typ, "cal type");
		wait_done(t);
		chk(strobes - n, 12, "bit decisions");
		chk(typ ? offset_coef : gain_coef, keep, "other coef");
		chk(typ ? gain_coef : offset_coef, 12'hfff, "stored coef");
		chk(sar_trial, 12'hfff, "final trial");
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(negedge clock) begin
		cyc++;
		if (sar_bit_strobe) strobes++;
		if (cyc > 20000) begin
			bad_count++;
			test_done;
		end
	end
	initial begin
		{sys_rst, sfr_wr, conv_start, conv_done, slow} = 5'h10;
		{sfr_addr, sfr_wdata, chan_sel} = 20'hf5000;
		repeat (10) @(negedge clock);
		sys_rst = 1'b0;
		rd(8'hf5);
		chk(d, 8'h00, "reset value");
		wr(8'hfa);
		rd(8'hf5);
		chk(d, 8'h7a, "busy read only");
		chk({gain_coef_enable, offset_coef_enable}, 2'h0, "coef disables");
		rd(8'h10);
		chk(d, 8'h00, "unmapped read");
		wr(8'h00);
		rd(8'hf5);
		chk({gain_coef_enable, offset_coef_enable}, 2'h3, "coef enables");
		for (int c = 0; c < 16; c++) begin
			@(negedge clock);
			chan_sel = c[3:0];
			repeat (2) @(negedge clock);
			chk({vref_sel, agnd_sel, second_dac_output_sel, first_dac_output_sel, temp_sensor_sel, ext_chan_enable},
				c < 6 ? 11'h1 << c : (c >= 8 && c <= 12) ? 11'h40 << (c - 8) : 11'h0, "channel steering");
		end
		cal(2'b00, 1'b0, 1'b0, len0);
		cal(2'b11, 1'b1, 1'b0, len1);
		chk(len1 > 3 * len0 && len0 >= 90, 1, "averaging length");
		cal(2'b01, 1'b0, 1'b1, len0);
		cal(2'b10, 1'b1, 1'b1, len0);
		@(negedge clock);
		conv_start = 1'b1;
		@(negedge clock);
		conv_start = 1'b0;
		rd(8'hf5);
		chk(d[7], 1, "conversion busy");
		wr(8'h05);
		repeat (3) @(negedge clock);
		chk(cal_active, 0, "start held off");
		conv_done = 1'b1;
		@(negedge clock);
		conv_done = 1'b0;
		wait_done(len0);
		test_done;
	end
endmodule
